// ==== rtl/scc_bank.sv ====
// Register bank for the channel B sensor supply controls and the two
// per-channel I/O status and configuration registers.
// Assumes a plain strobe register port on clk_i and asynchronous pins.
// Contract
// - Double-limit bit allows twice current above 18V
// - Limit-disable bit stops limiting, powers down amplifier
// - Supply enable turns on supply gate drive
// - Enable low holds current-limit timers in reset
// - Enable pulses shorter than 200us are ignored
// - Bit 7 reads digital input pin level
// - Bit 6 reads line pin level
// - Bit 5 replaces transmit-enable pin under override
// - Bit 4 replaces transmit data pin under override
// - Bit 3 enables 1.3us input glitch filter
// - Bit 2 selects type 2/3 thresholds
// - Bit 1 switches on input current source
// - Bit 0 switches on input current sink
// - Override disconnects transmit pins, registers drive line
`timescale 1ns/1ps
`default_nettype none
module scc_bank
  import scc_pkg::*;
#(
  parameter int EN_REJECT = EN_REJECT_CYCLES
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Channel pins sensed
  input  wire logic       input_a_pin_i,
  input  wire logic       input_b_pin_i,
  input  wire logic       line_a_pin_i,
  input  wire logic       line_b_pin_i,
  // External transmit pins
  input  wire logic       line_a_tx_pin_i,
  input  wire logic       line_a_tx_enable_pin_i,
  input  wire logic       line_b_tx_pin_i,
  input  wire logic       line_b_tx_enable_pin_i,
  // Control and supply sense levels
  input  wire logic       pin_override_select_i,
  input  wire logic       supply_b_above_18v_i,
  // Line transmitter controls
  output logic            line_a_tx_o,
  output logic            line_a_tx_enable_o,
  output logic            line_b_tx_o,
  output logic            line_b_tx_enable_o,
  // Digital input receiver controls
  output logic            input_a_threshold_select_o,
  output logic            input_a_source_enable_o,
  output logic            input_a_sink_enable_o,
  output logic            input_b_threshold_select_o,
  output logic            input_b_source_enable_o,
  output logic            input_b_sink_enable_o,
  // Channel B supply controls
  output logic            supply_b_double_limit_o,
  output logic            supply_b_limit_disable_o,
  output logic            supply_b_sense_power_down_o,
  output logic            supply_b_gate_drive_o,
  output logic            supply_b_timer_reset_o
);

  // ==========================================================================
  // Declarations
  logic                  rst_ff1_r;
  logic                  rst_n_r;
  logic [9:0]            pins_raw;
  logic [9:0]            pins_s;
  logic                  di_a_s;
  logic                  di_b_s;
  logic                  line_a_s;
  logic                  line_b_s;
  logic                  txa_s;
  logic                  line_a_tx_enable_pin_s;
  logic                  txb_s;
  logic                  line_b_soft_tx_enable_s;
  logic                  override_s;
  logic                  over18_s;
  logic                  level_a;
  logic                  level_b;
  logic                  en_q;
  logic [7:0]            supply_b_r;
  logic [5:0]            io_a_r;
  logic [5:0]            io_b_r;
  logic [7:0]            rdata_nxt;
  logic                  wr_sup;
  logic                  wr_a;
  logic                  wr_b;
  logic [QUAL_CNT_W-1:0] hold_cnt_r;

  // ==========================================================================
  // Read word of one channel: live levels above the stored control bits
  function automatic logic [7:0] io_word(input logic lvl, input logic line, input logic [5:0] ctrl);
    io_word = {lvl, line, ctrl};
  endfunction : io_word

  // ==========================================================================
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_ff1_r <= 1'b0;
      rst_n_r   <= 1'b0;
    end
    else
    begin
      rst_ff1_r <= 1'b1;
      rst_n_r   <= rst_ff1_r;
    end
  end

  // ==========================================================================
  // Pin synchronisers; every pin is asynchronous to clk_i
  assign pins_raw = {input_a_pin_i, input_b_pin_i, line_a_pin_i, line_b_pin_i,
                     line_a_tx_pin_i, line_a_tx_enable_pin_i, line_b_tx_pin_i,
                     line_b_tx_enable_pin_i, pin_override_select_i, supply_b_above_18v_i};

  scc_sync #(.W (10)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_r),
    .d_i     (pins_raw),
    .q_o     (pins_s)
  );

  // Split of the synchronised vector
  assign {di_a_s, di_b_s, line_a_s, line_b_s, txa_s, line_a_tx_enable_pin_s, txb_s, line_b_soft_tx_enable_s,
          override_s, over18_s} = pins_s;

  // ==========================================================================
  // Digital input glitch filters; bypass when the filter bit is clear
  scc_qualify #(.LIMIT (GLITCH_CYCLES)) u_filt_a (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_r),
    .bypass_i (!io_a_r[IO_FILT_BIT]),
    .d_i      (di_a_s),
    .q_o      (level_a)
  );

  scc_qualify #(.LIMIT (GLITCH_CYCLES)) u_filt_b (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_r),
    .bypass_i (!io_b_r[IO_FILT_BIT]),
    .d_i      (di_b_s),
    .q_o      (level_b)
  );

  // ==========================================================================
  // Supply enable pulse rejection; trades 200us of latency for immunity
  scc_qualify #(.LIMIT (EN_REJECT)) u_en_qual (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_r),
    .bypass_i (1'b0),
    .d_i      (supply_b_r[SUP_EN_BIT]),
    .q_o      (en_q)
  );

  // ==========================================================================
  // Write decode
  assign wr_sup = wr_i && (addr_i == ADDR_SUPPLY_B);
  assign wr_a   = wr_i && (addr_i == ADDR_IO_A);
  assign wr_b   = wr_i && (addr_i == ADDR_IO_B);

  // Supply register; upper bits are kept for read-back only
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      supply_b_r <= SUPPLY_B_RST;
    else if (wr_sup)
      supply_b_r <= wdata_i;
  end

  // Channel A controls; level bits are not storage, so writes drop them
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      io_a_r <= IO_CTRL_RST;
    else if (wr_a)
      io_a_r <= wdata_i[5:0];
  end

  // Channel B controls, separate flops from channel A
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      io_b_r <= IO_CTRL_RST;
    else if (wr_b)
      io_b_r <= wdata_i[5:0];
  end

  // ==========================================================================
  // Read mux; data stands only in the cycle after the strobe
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        ADDR_SUPPLY_B: rdata_nxt = supply_b_r;
        ADDR_IO_A:     rdata_nxt = io_word(level_a, line_a_s, io_a_r);
        ADDR_IO_B:     rdata_nxt = io_word(level_b, line_b_s, io_b_r);
        default:       rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rdata_o <= 8'h00;
    else
      rdata_o <= rdata_nxt;
  end

  // ==========================================================================
  // Transmitter source select: pins or register bits
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      line_a_tx_o        <= 1'b0;
      line_a_tx_enable_o <= 1'b0;
      line_b_tx_o        <= 1'b0;
      line_b_tx_enable_o <= 1'b0;
    end
    else
    begin
      line_a_tx_o        <= override_s ? io_a_r[IO_TX_BIT]   : txa_s;
      line_a_tx_enable_o <= override_s ? io_a_r[IO_TXEN_BIT] : line_a_tx_enable_pin_s;
      line_b_tx_o        <= override_s ? io_b_r[IO_TX_BIT]   : txb_s;
      line_b_tx_enable_o <= override_s ? io_b_r[IO_TXEN_BIT] : line_b_soft_tx_enable_s;
    end
  end

  // ==========================================================================
  // Receiver controls come straight from the control flops
  assign input_a_threshold_select_o = io_a_r[IO_THR_BIT];
  assign input_a_source_enable_o    = io_a_r[IO_SRC_BIT];
  assign input_a_sink_enable_o      = io_a_r[IO_SINK_BIT];
  assign input_b_threshold_select_o = io_b_r[IO_THR_BIT];
  assign input_b_source_enable_o    = io_b_r[IO_SRC_BIT];
  assign input_b_sink_enable_o      = io_b_r[IO_SINK_BIT];

  // ==========================================================================
  // Supply controls; the sense amplifier is off whenever limiting is off
  assign supply_b_limit_disable_o    = supply_b_r[SUP_LIMDIS_BIT];
  assign supply_b_sense_power_down_o = supply_b_r[SUP_LIMDIS_BIT];

  // Double limit only granted while the supply sits above 18V
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      supply_b_double_limit_o <= 1'b0;
    else
      supply_b_double_limit_o <= supply_b_r[SUP_DOUBLE_BIT] && over18_s;
  end

  // Gate drive and timer reset follow the qualified enable
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      supply_b_gate_drive_o  <= 1'b0;
      supply_b_timer_reset_o <= 1'b1;
    end
    else
    begin
      supply_b_gate_drive_o  <= en_q;
      supply_b_timer_reset_o <= !en_q;
    end
  end

  // ==========================================================================
  // Assertion helper: consecutive cycles the enable bit has been high
  always_ff @(posedge clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      hold_cnt_r <= '0;
    else if (!supply_b_r[SUP_EN_BIT])
      hold_cnt_r <= '0;
    else if (hold_cnt_r != '1)
      hold_cnt_r <= hold_cnt_r + 1'b1;
  end

  // ==========================================================================
  // Assertions
  sequence wr_a_seq;
    wr_i && (addr_i == ADDR_IO_A);
  endsequence

  sequence rd_a_seq;
    rd_i && (addr_i == ADDR_IO_A);
  endsequence

  double_limit_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      supply_b_double_limit_o == $past(supply_b_r[SUP_DOUBLE_BIT] && over18_s))
    else $error("double limit does not follow bit and 18V sense");
  limit_disable_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      (wr_i && addr_i == ADDR_SUPPLY_B) |=>
        supply_b_sense_power_down_o == $past(wdata_i[SUP_LIMDIS_BIT]))
    else $error("limit disable write not applied");
  gate_on_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      $rose(en_q) |=> supply_b_gate_drive_o && !supply_b_timer_reset_o)
    else $error("gate drive missing after enable");
  timer_hold_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      !en_q |=> supply_b_timer_reset_o && !supply_b_gate_drive_o)
    else $error("timers not held while disabled");
  pulse_reject_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      $rose(en_q) |-> hold_cnt_r == QUAL_CNT_W'(EN_REJECT))
    else $error("enable qualified after wrong hold time");
  input_level_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      rd_a_seq |=> rdata_o[IO_LEVEL_BIT] == $past(level_a))
    else $error("input level bit wrong");
  line_level_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      rd_a_seq |=> rdata_o[IO_LINE_BIT] == $past(line_a_s))
    else $error("line level bit wrong");
  soft_txen_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      override_s |=> line_a_tx_enable_o == $past(io_a_r[IO_TXEN_BIT]))
    else $error("soft transmit enable not applied");
  soft_tx_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      override_s |=> line_b_tx_o == $past(io_b_r[IO_TX_BIT]))
    else $error("soft transmit data not applied");

  pin_path_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      !override_s |=> line_a_tx_o == $past(txa_s) && line_a_tx_enable_o == $past(line_a_tx_enable_pin_s))
    else $error("pins not routed without override");

  filter_bypass_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      (!io_a_r[IO_FILT_BIT] && !wr_a) |=> level_a == $past(di_a_s))
    else $error("bypassed filter does not follow input");

  receiver_ctrl_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      wr_a_seq |=> {input_a_threshold_select_o, input_a_source_enable_o,
                    input_a_sink_enable_o} == $past(wdata_i[2:0]))
    else $error("receiver controls not written");

  isolation_a :
    assert property (@(posedge clk_i) disable iff (!rst_n_r)
      wr_a_seq |=> $stable(io_b_r))
    else $error("channel A write disturbed channel B");

endmodule : scc_bank
`default_nettype wire

// ==== rtl/scc_pkg.sv ====
// Package for the supply and I/O channel configuration bank.
// Assumes a 25 MHz core clock and byte-wide registers on a plain strobe port.
package scc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_SUPPLY_B = 8'h19;
  localparam logic [7:0] ADDR_IO_A     = 8'h1a;
  localparam logic [7:0] ADDR_IO_B     = 8'h1b;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SUPPLY_B_RST = 8'h00;
  localparam logic [5:0] IO_CTRL_RST  = 6'h00;

  // ==========================================================================
  // Field positions of the supply register
  localparam int SUP_DOUBLE_BIT = 2;
  localparam int SUP_LIMDIS_BIT = 1;
  localparam int SUP_EN_BIT     = 0;

  // ==========================================================================
  // Field positions of the I/O registers
  localparam int IO_LEVEL_BIT = 7;
  localparam int IO_LINE_BIT  = 6;
  localparam int IO_TXEN_BIT  = 5;
  localparam int IO_TX_BIT    = 4;
  localparam int IO_FILT_BIT  = 3;
  localparam int IO_THR_BIT   = 2;
  localparam int IO_SRC_BIT   = 1;
  localparam int IO_SINK_BIT  = 0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 40;
  localparam int GLITCH_TIME_NS   = 1300;
  localparam int GLITCH_CYCLES    = (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_REJECT_US     = 200;
  localparam int EN_REJECT_CYCLES = (EN_REJECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUAL_CNT_W       = 13;

endpackage : scc_pkg

// ==== rtl/scc_sync.sv ====
// Two-stage synchroniser for a vector of unrelated pin levels.
// Assumes each bit is an independent level; no word coherence is implied.
`timescale 1ns/1ps
`default_nettype none
module scc_sync
  import scc_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : scc_sync
`default_nettype wire

// ==== rtl/scc_qualify.sv ====
// Stability qualifier: output follows input once it has differed for LIMIT cycles.
// Assumes the input is already on this clock; bypass makes the output a plain copy.
`timescale 1ns/1ps
`default_nettype none
module scc_qualify
  import scc_pkg::*;
#(
  parameter int LIMIT = GLITCH_CYCLES
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Level in and qualified level out
  input  wire logic bypass_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic [QUAL_CNT_W-1:0] cnt_r;

  // ==========================================================================
  // A disagreement must persist; any return to the old level restarts the count
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_o   <= 1'b0;
      cnt_r <= '0;
    end
    else if (bypass_i || d_i == q_o)
    begin
      q_o   <= d_i;
      cnt_r <= '0;
    end
    else if (cnt_r == QUAL_CNT_W'(LIMIT - 1))
    begin
      q_o   <= d_i;
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : scc_qualify
`default_nettype wire

// ==== test/scc_bank_tb.sv ====
// Self-checking bench for the supply and I/O channel configuration bank.
// Assumes the bank alone on one 25 MHz clock; the bench drives every pin itself.
`timescale 1ns/1ps
`default_nettype none
module scc_bank_tb
  import scc_pkg::*;
;

  // ==========================================================================
  // Signals
  // Short enable qualification keeps the run brief; expectations use REJ
  localparam int REJ = 20;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       in_a = 1'b0, in_b = 1'b0, ln_a = 1'b0, ln_b = 1'b0;
  logic       line_a_soft_tx = 1'b0, line_a_tx_enable_pin = 1'b0, line_b_soft_tx = 1'b0, line_b_soft_tx_enable = 1'b0;
  logic       ovr = 1'b0, hi18 = 1'b0;
  logic       tx_a_o, txen_a_o, tx_b_o, txen_b_o;
  logic       thr_a_o, src_a_o, snk_a_o, thr_b_o, src_b_o, snk_b_o;
  logic       dbl_o, limdis_o, pdn_o, gate_o, tmr_o;
  int         num_errors = 0;
  int         samples_checked = 0;
  logic [7:0] rv;

  // Comparison that never lets an unknown pass for a match
  `define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  // ==========================================================================
  // Clock and design
  always #20 clk_i = ~clk_i;

  scc_bank #(.EN_REJECT(REJ)) i_scc_bank (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .input_a_pin_i(in_a), .input_b_pin_i(in_b), .line_a_pin_i(ln_a),
    .line_b_pin_i(ln_b), .line_a_tx_pin_i(line_a_soft_tx), .line_a_tx_enable_pin_i(line_a_tx_enable_pin), .line_b_tx_pin_i(line_b_soft_tx),
    .line_b_tx_enable_pin_i(line_b_soft_tx_enable), .pin_override_select_i(ovr), .supply_b_above_18v_i(hi18),
    .line_a_tx_o(tx_a_o), .line_a_tx_enable_o(txen_a_o), .line_b_tx_o(tx_b_o),
    .line_b_tx_enable_o(txen_b_o), .input_a_threshold_select_o(thr_a_o),
    .input_a_source_enable_o(src_a_o), .input_a_sink_enable_o(snk_a_o),
    .input_b_threshold_select_o(thr_b_o), .input_b_source_enable_o(src_b_o),
    .input_b_sink_enable_o(snk_b_o), .supply_b_double_limit_o(dbl_o),
    .supply_b_limit_disable_o(limdis_o), .supply_b_sense_power_down_o(pdn_o),
    .supply_b_gate_drive_o(gate_o), .supply_b_timer_reset_o(tmr_o)
  );

  // ==========================================================================
  // Bus tasks: one-cycle strobes launched just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  // ==========================================================================
  // Scenarios
  // Reset values, unmapped place ignored
  task automatic t_reset;
    `CHECK(tmr_o, 1'b1)
    `CHECK(gate_o, 1'b0)
    rd(ADDR_SUPPLY_B, rv);
    `CHECK(rv, SUPPLY_B_RST)
    rd(ADDR_IO_A, rv);
    `CHECK(rv, 8'h00)
    rd(ADDR_IO_B, rv);
    `CHECK(rv, 8'h00)
    wr(8'h1c, 8'hff);
    rd(8'h1c, rv);
    `CHECK(rv, 8'h00)
    rd(ADDR_SUPPLY_B, rv);
    `CHECK(rv, 8'h00)
  endtask : t_reset

  // Each receiver control bit alone, channels kept apart
  task automatic t_receiver;
    for (int b = 0; b < 3; b++)
    begin
      wr(ADDR_IO_A, 8'h01 << b);
      wr(ADDR_IO_B, 8'h07 ^ (8'h01 << b));
      cyc(1);
      `CHECK({thr_a_o, src_a_o, snk_a_o}, 3'b001 << b)
      `CHECK({thr_b_o, src_b_o, snk_b_o}, 3'b111 ^ (3'b001 << b))
    end
    // Status bits cannot be written
    wr(ADDR_IO_A, 8'hff);
    rd(ADDR_IO_A, rv);
    `CHECK(rv, 8'h3f)
    rd(ADDR_IO_B, rv);
    `CHECK(rv, 8'h03)
    wr(ADDR_IO_A, 8'h00);
    wr(ADDR_IO_B, 8'h00);
  endtask : t_receiver

  // Pin levels, with filter bypassed on A and active on B
  task automatic t_levels;
    wr(ADDR_IO_B, 8'h08);
    ln_a <= 1'b1;
    cyc(4);
    rd(ADDR_IO_A, rv);
    `CHECK(rv, 8'h40)
    rd(ADDR_IO_B, rv);
    `CHECK(rv, 8'h08)
    ln_a <= 1'b0;
    ln_b <= 1'b1;
    cyc(4);
    rd(ADDR_IO_B, rv);
    `CHECK(rv, 8'h48)
    // A 10-cycle pulse passes A unfiltered but is dropped on B
    in_a <= 1'b1;
    in_b <= 1'b1;
    cyc(6);
    rd(ADDR_IO_A, rv);
    `CHECK(rv[7], 1'b1)
    rd(ADDR_IO_B, rv);
    `CHECK(rv[7], 1'b0)
    in_b <= 1'b0;
    cyc(GLITCH_CYCLES + 6);
    rd(ADDR_IO_B, rv);
    `CHECK(rv[7], 1'b0)
    // A steady level gets through the filter
    in_b <= 1'b1;
    cyc(GLITCH_CYCLES + 6);
    rd(ADDR_IO_B, rv);
    `CHECK(rv, 8'hc8)
    in_a <= 1'b0;
    cyc(6);
    rd(ADDR_IO_A, rv);
    `CHECK(rv[7], 1'b0)
    wr(ADDR_IO_B, 8'h00);
  endtask : t_levels

  // Transmitters from pins, then from register bits under override
  task automatic t_override;
    wr(ADDR_IO_A, 8'h00);
    wr(ADDR_IO_B, 8'h30);
    line_a_soft_tx <= 1'b1;
    line_a_tx_enable_pin <= 1'b1;
    line_b_soft_tx <= 1'b0;
    line_b_soft_tx_enable <= 1'b0;
    cyc(5);
    `CHECK({txen_a_o, tx_a_o, txen_b_o, tx_b_o}, 4'b1100)
    ovr <= 1'b1;
    cyc(5);
    `CHECK({txen_a_o, tx_a_o, txen_b_o, tx_b_o}, 4'b0011)
    wr(ADDR_IO_A, 8'h20);
    wr(ADDR_IO_B, 8'h10);
    line_b_soft_tx <= 1'b1;
    line_b_soft_tx_enable <= 1'b1;
    cyc(4);
    `CHECK({txen_a_o, tx_a_o, txen_b_o, tx_b_o}, 4'b1001)
    ovr <= 1'b0;
    cyc(5);
    `CHECK({txen_a_o, tx_a_o, txen_b_o, tx_b_o}, 4'b1111)
  endtask : t_override

  // Supply enable: short pulse dropped, long level qualified, limit bits
  task automatic t_supply;
    int n;
    wr(ADDR_SUPPLY_B, 8'h01);
    cyc(REJ / 2);
    wr(ADDR_SUPPLY_B, 8'h00);
    cyc(REJ + 5);
    `CHECK({gate_o, tmr_o}, 2'b01)
    wr(ADDR_SUPPLY_B, 8'h01);
    n = 0;
    // Look 1ns past each edge so the gate drive launched there has settled
    while (gate_o !== 1'b1 && n < REJ + 10)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHECK(n, REJ + 1)
    `CHECK(tmr_o, 1'b0)
    wr(ADDR_SUPPLY_B, 8'h03);
    cyc(1);
    `CHECK({limdis_o, pdn_o, gate_o}, 3'b111)
    wr(ADDR_SUPPLY_B, 8'h05);
    cyc(4);
    `CHECK({limdis_o, pdn_o, dbl_o}, 3'b000)
    hi18 <= 1'b1;
    cyc(4);
    `CHECK(dbl_o, 1'b1)
    wr(ADDR_SUPPLY_B, 8'hf9);
    cyc(2);
    `CHECK(dbl_o, 1'b0)
    rd(ADDR_SUPPLY_B, rv);
    `CHECK(rv, 8'hf9)
    wr(ADDR_SUPPLY_B, 8'hf8);
    cyc(REJ - 4);
    `CHECK({gate_o, tmr_o}, 2'b10)
    cyc(8);
    `CHECK({gate_o, tmr_o}, 2'b01)
  endtask : t_supply

  // ==========================================================================
  // Verdict
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    #(40 * 20000);
    num_errors++;
    close_out();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(3);
    t_reset();
    t_receiver();
    t_levels();
    t_override();
    t_supply();
    close_out();
  end

endmodule : scc_bank_tb
`default_nettype wire
